/* hw/gcsma_regs.v */
// gigabit config/status registers and indirect extended-register access
`timescale 1ns/1ns
`default_nettype none

`include "gcsma_defs.vh"

// What this block does
// RL1: three-bit compliance pattern select, zero is normal, one to seven pick patterns.
// RL2: manual role enable bypasses automatic master/slave resolution, taking role bit.
// RL3: manual role value one forces master, zero forces slave.
// RL4: port type bit declares multi-port or single-port, resets to zero.
// RL5: gigabit full/half duplex advertise bits reset one, overridden by straps.
// RL6: diagnostic auto-run bit starts cable diagnostic on each link loss.
// RL7: role fault latches high until status register is read; read clears.
// RL8: status shows resolved role, one master, zero slave.
// RL9: status shows local and remote receiver health, one is good.
// RL10: status shows partner gigabit full/half duplex ability, zero after reset.
// RL11: status low byte is idle error count, reset to zero.
// RL12: function field picks address, data, increment on all or writes only.
// RL13: five-bit space number steers every indirect access to that space.
// RL14: software writes 0x1f into space number to reach vendor registers.
// RL15: address/data register hits pointer in address mode, else data.
// RL16: reserved bits read zero and ignore writes.
module gcsma_regs (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [4:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  input wire strap_adv_full_i,
  input wire strap_adv_half_i,
  input wire auto_role_master_i,
  input wire role_fault_i,
  input wire local_receiver_ok_i,
  input wire remote_receiver_ok_i,
  input wire partner_gig_full_duplex_i,
  input wire partner_gig_half_duplex_i,
  input wire idle_error_i,
  input wire link_up_i,
  output reg [15:0] reg_rdata_o,
  output reg [2:0] test_pattern_o,
  output reg role_master_o,
  output reg multi_port_o,
  output reg adv_gig_full_duplex_o,
  output reg adv_gig_half_duplex_o,
  output reg cable_diag_start_o
);

  // ========================================================================
  // input synchronisers (pins from the line side)
  reg [9:0] sync_a;
  reg [9:0] sync_b;
  wire [9:0] pins_raw;

  assign pins_raw = {strap_adv_full_i, strap_adv_half_i, auto_role_master_i,
                     role_fault_i, local_receiver_ok_i, remote_receiver_ok_i,
                     partner_gig_full_duplex_i, partner_gig_half_duplex_i,
                     idle_error_i, link_up_i};

  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1) begin : gen_sync
      always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= pins_raw[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  wire s_strap_full = sync_b[9];
  wire s_strap_half = sync_b[8];
  wire s_auto_master = sync_b[7];
  wire s_fault = sync_b[6];
  wire s_local_ok = sync_b[5];
  wire s_remote_ok = sync_b[4];
  wire s_partner_fd = sync_b[3];
  wire s_partner_hd = sync_b[2];
  wire s_idle_err = sync_b[1];
  wire s_link_up = sync_b[0];

  // ========================================================================
  // access decode
  wire hit_cfg = (reg_addr_i == `GCSMA_OFS_CONFIG);
  wire hit_sts = (reg_addr_i == `GCSMA_OFS_STATUS);
  wire hit_ctl = (reg_addr_i == `GCSMA_OFS_IND_CTRL);
  wire hit_ad = (reg_addr_i == `GCSMA_OFS_IND_ADDR_DATA);

  // ========================================================================
  // configuration register
  reg [15:0] cfg;
  // strap capture waits until the synchroniser has flushed after release
  reg [1:0] strap_wait;
  reg strap_done;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg <= `GCSMA_RST_CONFIG;
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
    end else begin
      if (!strap_done) begin
        strap_wait <= strap_wait + 2'h1;
        if (strap_wait == 2'h2) begin
          strap_done <= 1'b1;
          cfg[`GCSMA_CFG_ADV_FD] <= s_strap_full; // [RL5]
          cfg[`GCSMA_CFG_ADV_HD] <= s_strap_half; // [RL5]
        end
      end
      if (reg_wr_i && hit_cfg) begin
        cfg <= reg_wdata_i & `GCSMA_CFG_WRITABLE_MASK; // [RL16]
      end
    end
  end

  // ========================================================================
  // status register
  reg fault_latched;
  reg [7:0] idle_errs;
  wire sts_read = reg_rd_i && hit_sts;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fault_latched <= 1'b0;
      idle_errs <= 8'h00;
    end else begin
      // a fault arriving during the clearing read still wins
      if (s_fault) begin
        fault_latched <= 1'b1; // [RL7]
      end else if (sts_read) begin
        fault_latched <= 1'b0; // [RL7]
      end
      // saturates so a long burst does not wrap back to a small count
      if (s_idle_err && s_link_up && idle_errs != 8'hff) begin
        idle_errs <= idle_errs + 8'h01; // [RL11]
      end
    end
  end

  wire [15:0] sts_word = {fault_latched, role_master_o, s_local_ok,
                          s_remote_ok, s_partner_fd, s_partner_hd,
                          2'h0, idle_errs}; // [RL8] [RL9] [RL10] [RL16]

  // ========================================================================
  // indirect access control and address pointer
  reg [1:0] func;
  reg [4:0] space;
  reg [15:0] pointer [0:`GCSMA_EXT_SPACES-1];
  wire [15:0] cur_ptr = pointer[space];
  wire [15:0] ext_rdata;
  wire data_mode = (func != `GCSMA_FUNC_ADDRESS);
  wire ad_wr = reg_wr_i && hit_ad;
  wire ad_rd = reg_rd_i && hit_ad;
  reg bump;

  always @* begin
    bump = 1'b0;
    if (func == `GCSMA_FUNC_DATA_INC_RW) begin
      bump = ad_wr || ad_rd; // [RL12]
    end else if (func == `GCSMA_FUNC_DATA_INC_WR) begin
      bump = ad_wr; // [RL12]
    end
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      func <= 2'h0;
      space <= 5'h00;
    end else if (reg_wr_i && hit_ctl) begin
      func <= reg_wdata_i[`GCSMA_IND_FUNC_HI:`GCSMA_IND_FUNC_LO]; // [RL12]
      space <= reg_wdata_i[`GCSMA_IND_SPACE_HI:`GCSMA_IND_SPACE_LO]; // [RL13]
    end
  end

  // one pointer per space, so switching space keeps each space's position
  generate
    for (g = 0; g < `GCSMA_EXT_SPACES; g = g + 1) begin : gen_ptr
      always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          pointer[g] <= `GCSMA_RST_IND_ADDR_DATA;
        end else if (space == g) begin
          if (ad_wr && !data_mode) begin
            pointer[g] <= reg_wdata_i; // [RL15]
          end else if (bump) begin
            pointer[g] <= cur_ptr + 16'h0001; // [RL12]
          end
        end
      end
    end
  endgenerate

  gcsma_ext_space u_ext (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .space_i(space), // [RL13] [RL14]
    .addr_i(cur_ptr),
    .wr_i(ad_wr && data_mode), // [RL15]
    .wdata_i(reg_wdata_i),
    .rdata_o(ext_rdata)
  );

  // ========================================================================
  // outputs and read data
  reg link_seen;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
      test_pattern_o <= 3'h0;
      role_master_o <= 1'b0;
      multi_port_o <= 1'b0;
      adv_gig_full_duplex_o <= 1'b1;
      adv_gig_half_duplex_o <= 1'b1;
      cable_diag_start_o <= 1'b0;
      link_seen <= 1'b0;
    end else begin
      test_pattern_o <= cfg[`GCSMA_CFG_PATTERN_HI:`GCSMA_CFG_PATTERN_LO]; // [RL1]
      if (cfg[`GCSMA_CFG_MANUAL_ROLE_ENABLE]) begin
        role_master_o <= cfg[`GCSMA_CFG_MANUAL_ROLE_VALUE]; // [RL2] [RL3]
      end else begin
        role_master_o <= s_auto_master; // [RL2]
      end
      multi_port_o <= cfg[`GCSMA_CFG_PORT_TYPE]; // [RL4]
      adv_gig_full_duplex_o <= cfg[`GCSMA_CFG_ADV_FD]; // [RL5]
      adv_gig_half_duplex_o <= cfg[`GCSMA_CFG_ADV_HD]; // [RL5]
      link_seen <= s_link_up;
      cable_diag_start_o <= cfg[`GCSMA_CFG_DIAG_AUTO] &&
                            link_seen && !s_link_up; // [RL6]
      if (reg_rd_i) begin
        if (hit_cfg) begin
          reg_rdata_o <= cfg;
        end else if (hit_sts) begin
          reg_rdata_o <= sts_word;
        end else if (hit_ctl) begin
          reg_rdata_o <= {func, 9'h000, space}; // [RL16]
        end else if (hit_ad) begin
          reg_rdata_o <= data_mode ? ext_rdata : cur_ptr; // [RL15]
        end else begin
          reg_rdata_o <= 16'h0000;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* hw/gcsma_defs.vh */
// register offsets, field positions, reset values for the gigabit cfg/status block
`ifndef GCSMA_DEFS_VH
`define GCSMA_DEFS_VH

// ==========================================================================
// register offsets (management register numbers)
`define GCSMA_OFS_CONFIG 5'h09
`define GCSMA_OFS_STATUS 5'h0a
`define GCSMA_OFS_IND_CTRL 5'h0d
`define GCSMA_OFS_IND_ADDR_DATA 5'h0e

// ==========================================================================
// reset values
`define GCSMA_RST_CONFIG 16'h0300
`define GCSMA_RST_STATUS 16'h0000
`define GCSMA_RST_IND_CTRL 16'h0000
`define GCSMA_RST_IND_ADDR_DATA 16'h0000

// ==========================================================================
// configuration register fields
`define GCSMA_CFG_PATTERN_HI 15
`define GCSMA_CFG_PATTERN_LO 13
`define GCSMA_CFG_MANUAL_ROLE_ENABLE 12
`define GCSMA_CFG_MANUAL_ROLE_VALUE 11
`define GCSMA_CFG_PORT_TYPE 10
`define GCSMA_CFG_ADV_FD 9
`define GCSMA_CFG_ADV_HD 8
`define GCSMA_CFG_DIAG_AUTO 7
`define GCSMA_CFG_WRITABLE_MASK 16'hff80

// ==========================================================================
// status register fields
`define GCSMA_STS_ROLE_FAULT 15
`define GCSMA_STS_ROLE_RESOLVED 14
`define GCSMA_STS_LOCAL_RX_OK 13
`define GCSMA_STS_REMOTE_RX_OK 12
`define GCSMA_STS_PARTNER_FD 11
`define GCSMA_STS_PARTNER_HD 10
`define GCSMA_STS_IDLE_ERR_HI 7
`define GCSMA_STS_IDLE_ERR_LO 0

// ==========================================================================
// indirect access control fields and function codes
`define GCSMA_IND_FUNC_HI 15
`define GCSMA_IND_FUNC_LO 14
`define GCSMA_IND_SPACE_HI 4
`define GCSMA_IND_SPACE_LO 0
`define GCSMA_FUNC_ADDRESS 2'h0
`define GCSMA_FUNC_DATA_FIXED 2'h1
`define GCSMA_FUNC_DATA_INC_RW 2'h2
`define GCSMA_FUNC_DATA_INC_WR 2'h3

// ==========================================================================
// extended register space geometry
`define GCSMA_EXT_SPACES 32
`define GCSMA_EXT_WORDS 16
`define GCSMA_EXT_INDEX_W 4

`endif

/* hw/gcsma_ext_space.v */
// extended register storage reached through the indirect access pair
`timescale 1ns/1ns
`default_nettype none

`include "gcsma_defs.vh"

module gcsma_ext_space (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [4:0] space_i,
  input wire [15:0] addr_i,
  input wire wr_i,
  input wire [15:0] wdata_i,
  output wire [15:0] rdata_o
);

  // ========================================================================
  // storage
  // only the low address bits index the store; higher pointer bits alias
  reg [15:0] mem [0:`GCSMA_EXT_SPACES*`GCSMA_EXT_WORDS-1];
  wire [8:0] index;

  assign index = {space_i, addr_i[`GCSMA_EXT_INDEX_W-1:0]};
  assign rdata_o = mem[index];

  always @(posedge clk_sys_i) begin
    if (wr_i && !rst_i) begin
      mem[index] <= wdata_i;
    end
  end

endmodule

`default_nettype wire

/* testbench/gcsma_regs_props.sv */
// concurrent checks on the gigabit cfg/status register block ports
`timescale 1ns/1ns
`default_nettype none
module gcsma_regs_props (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic auto_role_master_i,
  input wire logic link_up_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [2:0] test_pattern_o,
  input wire logic role_master_o,
  input wire logic multi_port_o,
  input wire logic adv_gig_full_duplex_o,
  input wire logic adv_gig_half_duplex_o,
  input wire logic cable_diag_start_o
);
  // ==========================================================
  // config shadow; q counts edges since the last config write
  logic [15:0] sh;
  logic [2:0] q;
  wire cw = reg_wr_i && reg_addr_i == 5'h09;
  wire mapd = reg_addr_i inside {5'h09, 5'h0a, 5'h0d, 5'h0e};
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sh <= 16'h0300;
      q <= 3'h0;
    end else if (cw) begin
      sh <= reg_wdata_i;
      q <= 3'h1;
    end else if (q != 3'h0 && q != 3'h7) begin
      q <= q + 3'h1;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  pat_follow_a: assert property (q >= 3'h4 |->
    test_pattern_o == sh[15:13]) else $error("pattern output wrong");
  port_type_a: assert property (q >= 3'h4 |->
    multi_port_o == sh[10]) else $error("port type output wrong");
  adv_follow_a: assert property (q >= 3'h4 |->
    {adv_gig_full_duplex_o, adv_gig_half_duplex_o} == sh[9:8])
    else $error("advertise outputs wrong");
  man_role_a: assert property (q >= 3'h4 && sh[12] |->
    role_master_o == sh[11]) else $error("manual role wrong");
  auto_role_a: assert property (
    (q >= 3'h4 && !sh[12] && $stable(auto_role_master_i))[*5] |->
    role_master_o == auto_role_master_i) else $error("auto role wrong");
  unmap_zero_a: assert property (
    reg_rd_i && !mapd ##1 !reg_rd_i |-> ##1 reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!reg_rd_i && !$past(reg_rd_i) &&
    !$past(reg_rd_i, 2) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  diag_start_a: assert property (
    $fell(link_up_i) && sh[7] && q >= 3'h4 |-> ##[2:5] cable_diag_start_o)
    else $error("no diagnostic start on link loss");
  diag_one_a: assert property (
    cable_diag_start_o |=> !cable_diag_start_o)
    else $error("diagnostic start longer than a cycle");
  no_diag_a: assert property (!sh[7] && q == 3'h7 |->
    !cable_diag_start_o) else $error("diagnostic start while disabled");
  cover property (cw ##4 test_pattern_o == 3'h7);
  cover property (cable_diag_start_o);
  cover property (reg_rd_i && !mapd);
endmodule
bind gcsma_regs gcsma_regs_props u_props (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .auto_role_master_i(auto_role_master_i), .link_up_i(link_up_i),
  .reg_rdata_o(reg_rdata_o), .test_pattern_o(test_pattern_o),
  .role_master_o(role_master_o), .multi_port_o(multi_port_o),
  .adv_gig_full_duplex_o(adv_gig_full_duplex_o),
  .adv_gig_half_duplex_o(adv_gig_half_duplex_o),
  .cable_diag_start_o(cable_diag_start_o));
`default_nettype wire

/* testbench/gcsma_mgmt_model.sv */
// management controller model driving the register strobes
`timescale 1ns/1ns
`default_nettype none
module gcsma_mgmt_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] rdata_i,
  output logic [4:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] wdata_o
);
  // ==========================================================
  // strobes move at the falling edge and span one rising edge
  initial begin
    addr_o = 5'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_sys_i);
    wr_o = 1'b0;
    // released data is inverted so a stale word cannot pass
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_sys_i);
    rd_o = 1'b0;
    @(negedge clk_sys_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* testbench/gcsma_regs_tb_top.sv */
// self-checking bench for the gigabit cfg/status register block
`timescale 1ns/1ns
`default_nettype none
module gcsma_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic st_f = 1'b1, st_h = 1'b1, auto_m = 1'b0, fault = 1'b0;
  logic l_ok = 1'b0, r_ok = 1'b0, p_fd = 1'b0, p_hd = 1'b0;
  logic idle_e = 1'b0, link = 1'b0, wr, rd, role, mport, adv_f, adv_h;
  logic diag;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, v;
  logic [2:0] pat;
  int n_fail = 0, tests_run = 0, cyc = 0;
  // ==========================================================
  // indirect access script: 1 = write, 2 = read and compare
  logic [23:0] ops [35] = '{24'h1dffff, 24'h2dc01f, 24'h1d001f,
    24'h1e0004, 24'h1d401f, 24'h1ea5a5, 24'h2ea5a5, 24'h2ea5a5,
    24'h1d001f, 24'h2e0004, 24'h1d801f, 24'h1e1111, 24'h1e2222,
    24'h1d001f, 24'h2e0006, 24'h1e0004, 24'h1d801f, 24'h2e1111,
    24'h2e2222, 24'h1d001f, 24'h1e0004, 24'h1dc01f, 24'h2e1111,
    24'h2e1111, 24'h1e3333, 24'h1d001f, 24'h2e0005, 24'h1d0002,
    24'h1e0006, 24'h1d4002, 24'h1e7777, 24'h1d401f, 24'h2e2222,
    24'h1d4002, 24'h2e7777};
  always #25 clk = ~clk;
  gcsma_mgmt_model mm (.clk_sys_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  gcsma_regs uut (.clk_sys_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .strap_adv_full_i(st_f), .strap_adv_half_i(st_h),
    .auto_role_master_i(auto_m), .role_fault_i(fault),
    .local_receiver_ok_i(l_ok), .remote_receiver_ok_i(r_ok),
    .partner_gig_full_duplex_i(p_fd), .partner_gig_half_duplex_i(p_hd),
    .idle_error_i(idle_e), .link_up_i(link), .reg_rdata_o(rdata),
    .test_pattern_o(pat), .role_master_o(role), .multi_port_o(mport),
    .adv_gig_full_duplex_o(adv_f), .adv_gig_half_duplex_o(adv_h),
    .cable_diag_start_o(diag));
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rchk(input string n, input logic [4:0] a,
                      input logic [15:0] e);
    mm.rd(a, v);
    chk(n, v, e);
  endtask
  task automatic t_reset;
    chk("adv", {14'h0, adv_f, adv_h}, 16'h0003);
    rchk("cfg", 5'h09, 16'h0300);
    rchk("sts", 5'h0a, 16'h0000);
    rchk("ctl", 5'h0d, 16'h0000);
    rchk("ad", 5'h0e, 16'h0000);
    mm.wr(5'h03, 16'hffff);
    mm.wr(5'h0a, 16'hffff);
    rchk("unmapped", 5'h03, 16'h0000);
    rchk("sts ro", 5'h0a, 16'h0000);
  endtask
  task automatic t_cfg;
    for (int p = 0; p < 8; p++) begin
      mm.wr(5'h09, {p[2:0], 13'h0300});
      wt(4);
      chk("pattern", 16'(pat), 16'(p[2:0]));
    end
    mm.wr(5'h09, 16'hfeff);
    wt(4);
    rchk("cfg mask", 5'h09, 16'hfe80);
    chk("port", 16'(mport), 16'h0001);
    chk("adv", {14'h0, adv_f, adv_h}, 16'h0002);
    chk("man master", 16'(role), 16'h0001);
    rchk("res master", 5'h0a, 16'h4000);
    auto_m = 1'b1;
    mm.wr(5'h09, 16'h1000);
    wt(5);
    chk("man slave", 16'(role), 16'h0000);
    rchk("res slave", 5'h0a, 16'h0000);
    mm.wr(5'h09, 16'h0000);
    wt(5);
    chk("auto master", 16'(role), 16'h0001);
    auto_m = 1'b0;
    wt(5);
    chk("auto slave", 16'(role), 16'h0000);
  endtask
  task automatic t_sts;
    {l_ok, r_ok, p_fd, p_hd, link} = 5'h1f;
    wt(4);
    idle_e = 1'b1;
    wt(3);
    idle_e = 1'b0;
    wt(3);
    rchk("sts on", 5'h0a, 16'h3c03);
    link = 1'b0;
    wt(3);
    idle_e = 1'b1;
    wt(2);
    {l_ok, r_ok, p_fd, p_hd, idle_e} = 5'h00;
    wt(4);
    rchk("sts off", 5'h0a, 16'h0003);
    fault = 1'b1;
    wt(1);
    fault = 1'b0;
    wt(6);
    rchk("fault set", 5'h0a, 16'h8003);
    rchk("fault clr", 5'h0a, 16'h0003);
  endtask
  task automatic t_diag;
    logic [3:0] n;
    for (int k = 0; k < 2; k++) begin
      n = 4'h0;
      mm.wr(5'h09, k ? 16'h0000 : 16'h0080);
      link = 1'b1;
      wt(6);
      link = 1'b0;
      repeat (8) begin
        @(negedge clk);
        n = n + 4'(diag);
      end
      chk("diag runs", 16'(n), k ? 16'h0000 : 16'h0001);
    end
  endtask
  task automatic t_ind;
    foreach (ops[i]) begin
      if (ops[i][23:20] == 4'h1)
        mm.wr({1'b0, ops[i][19:16]}, ops[i][15:0]);
      else
        rchk("ind", {1'b0, ops[i][19:16]}, ops[i][15:0]);
    end
  endtask
  // second reset with one strap low: the strap must win over the default
  task automatic t_strap;
    st_f = 1'b0;
    wt(1);
    rst = 1'b1;
    wt(2);
    rst = 1'b0;
    wt(6);
    chk("strap adv", {14'h0, adv_f, adv_h}, 16'h0001);
    rchk("strap cfg", 5'h09, 16'h0100);
  endtask
  // a hang counts as a mismatch and closes the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    wt(2);
    rst = 1'b0;
    wt(6);
    t_reset;
    t_cfg;
    t_sts;
    t_diag;
    t_ind;
    t_strap;
    test_done;
  end
endmodule
`default_nettype wire
